// ===== mgrade_pkg.sv
// Shared constants and types for the membership grade evaluator
package mgrade_pkg;

   // ----------------------------------------
   // Definition record layout in memory
   // ----------------------------------------
   localparam logic [1:0] FLD_POINT_LEFT = 2'h0;
   localparam logic [1:0] FLD_POINT_RIGHT = 2'h1;
   localparam logic [1:0] FLD_SLOPE_LEFT = 2'h2;
   localparam logic [1:0] FLD_SLOPE_RIGHT = 2'h3;
   localparam int DEF_STRIDE = 4;
   localparam int FUZ_STRIDE = 1;

   // ----------------------------------------
   // Grade and slope values
   // ----------------------------------------
   localparam logic [7:0] GRADE_MAX = 8'hFF;
   localparam logic [7:0] GRADE_ZERO = 8'h00;
   localparam logic [7:0] SLOPE_VERTICAL = 8'h00;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_FETCH = 6'b000010,
      ST_DIFF = 6'b000100,
      ST_PROD = 6'b001000,
      ST_SEL = 6'b010000,
      ST_STORE = 6'b100000
   } seq_state_t;

endpackage : mgrade_pkg

// ===== grade_if.sv
// Operand and result bundle between sequencer and grade arithmetic
`timescale 1ns/1ps
`default_nettype none
interface grade_if;
   logic [7:0] ain;
   logic [7:0] p1;
   logic [7:0] p2;
   logic [7:0] s1;
   logic [7:0] s2;
   logic diff_en;
   logic prod_en;
   logic flag;
   logic [15:0] g1;
   logic [15:0] g2;

   modport ctrl (output ain, p1, p2, s1, s2, diff_en, prod_en, input flag, g1, g2);
   modport calc (input ain, p1, p2, s1, s2, diff_en, prod_en, output flag, g1, g2);
endinterface : grade_if
`default_nettype wire

// ===== grade_unit.sv
// Difference, outside flag and tentative grade arithmetic
`timescale 1ns/1ps
`default_nettype none
module grade_unit
   import mgrade_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Operands and results
   grade_if.calc gi
);

   typedef struct packed {
      logic [7:0] d1;
      logic [7:0] d2;
      logic flag;
      logic [15:0] g1;
      logic [15:0] g2;
   } unit_state_t;

   unit_state_t q;
   unit_state_t d;
   logic b1;
   logic b2;
   logic [7:0] r1;
   logic [7:0] r2;

   always_comb begin
      d = q;
      {b1, r1} = {1'b0, gi.ain} - {1'b0, gi.p1};
      {b2, r2} = {1'b0, gi.p2} - {1'b0, gi.ain};
      if (gi.diff_en) begin
         d.d1 = r1;
         d.d2 = r2;
         d.flag = b1 | b2;
      end
      if (gi.prod_en) begin
         if (q.flag) begin
            d.g1 = 16'h0000;
            d.g2 = 16'h0000;
         end else begin
            d.g1 = 16'(q.d1) * 16'(gi.s1);
            d.g2 = 16'(q.d2) * 16'(gi.s2);
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign gi.flag = q.flag;
   assign gi.g1 = q.g1;
   assign gi.g2 = q.g2;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_flag_set;
      @(posedge clock_in) disable iff (rst_in)
      gi.diff_en && ((gi.ain < gi.p1) || (gi.ain > gi.p2)) |=> gi.flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("outside flag not set");

   property p_flag_clear;
      @(posedge clock_in) disable iff (rst_in)
      gi.diff_en ##1 !gi.flag |-> ($past(gi.ain) >= $past(gi.p1)) && ($past(gi.ain) <= $past(gi.p2));
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear outside range");

   property p_force_zero;
      @(posedge clock_in) disable iff (rst_in)
      gi.prod_en && gi.flag |=> (gi.g1 == 16'h0000) && (gi.g2 == 16'h0000);
   endproperty
   a_force_zero: assert property (p_force_zero) else $error("tentative grades not forced");

   property p_product;
      @(posedge clock_in) disable iff (rst_in)
      gi.prod_en && !gi.flag |=>
         (gi.g2 == (16'($past(gi.p2)) - 16'($past(gi.ain))) * 16'($past(gi.s2)))
         && (gi.g1 == (16'($past(gi.ain)) - 16'($past(gi.p1))) * 16'($past(gi.s1)));
   endproperty
   a_product: assert property (p_product) else $error("tentative grade product wrong");

endmodule : grade_unit
`default_nettype wire

// ===== membership_grade_eval.sv
// Trapezoid membership grade evaluator: sequencer and grade selection
`timescale 1ns/1ps
`default_nettype none
module membership_grade_eval
   import mgrade_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Core request
   input wire logic start_in,
   input wire logic [7:0] value_in,
   input wire logic [ADDR_W-1:0] def_ptr_in,
   input wire logic [ADDR_W-1:0] fuzzy_ptr_in,
   // Core answer
   output logic busy_out,
   output logic done_out,
   output logic [7:0] grade_out,
   output logic [ADDR_W-1:0] def_ptr_out,
   output logic [ADDR_W-1:0] fuzzy_ptr_out,
   // Memory
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [7:0] mem_rdata_in
);

   typedef struct packed {
      seq_state_t st;
      logic [1:0] idx;
      logic [7:0] ain;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] dptr;
      logic [ADDR_W-1:0] fptr;
      logic [7:0] grade;
      logic done;
   } eval_state_t;

   eval_state_t q;
   eval_state_t d;
   logic [7:0] step1;
   logic [7:0] step2;

   grade_if gi ();

   grade_unit u_grade (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .gi(gi)
   );

   // ----------------------------------------
   // Grade selection
   // ----------------------------------------
   always_comb begin
      step1 = gi.g2[7:0];
      if (((q.s2 == SLOPE_VERTICAL) || (gi.g2 > 16'(GRADE_MAX))) && !gi.flag) begin
         step1 = GRADE_MAX;
      end
      step2 = gi.g1[7:0];
      if ((q.s1 == SLOPE_VERTICAL) || (gi.g1 > 16'(GRADE_MAX))) begin
         step2 = step1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      d = q;
      d.done = 1'b0;
      unique case (q.st)
         ST_IDLE: begin
            if (start_in) begin
               d.ain = value_in;
               d.dptr = def_ptr_in;
               d.fptr = fuzzy_ptr_in;
               d.addr = def_ptr_in;
               d.idx = FLD_POINT_LEFT;
               d.st = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (mem_ack_in) begin
               unique case (q.idx)
                  FLD_POINT_LEFT: d.p1 = mem_rdata_in;
                  FLD_POINT_RIGHT: d.p2 = mem_rdata_in;
                  FLD_SLOPE_LEFT: d.s1 = mem_rdata_in;
                  FLD_SLOPE_RIGHT: d.s2 = mem_rdata_in;
               endcase
               d.addr = q.addr + ADDR_W'(1);
               d.idx = q.idx + 2'h1;
               if (q.idx == FLD_SLOPE_RIGHT) begin
                  d.st = ST_DIFF;
               end
            end
         end
         ST_DIFF: d.st = ST_PROD;
         ST_PROD: d.st = ST_SEL;
         ST_SEL: begin
            d.grade = step2;
            d.addr = q.fptr;
            d.st = ST_STORE;
         end
         ST_STORE: begin
            if (mem_ack_in) begin
               d.dptr = q.dptr + ADDR_W'(DEF_STRIDE);
               d.fptr = q.fptr + ADDR_W'(FUZ_STRIDE);
               d.done = 1'b1;
               d.st = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         q <= '{st: ST_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign gi.ain = q.ain;
   assign gi.p1 = q.p1;
   assign gi.p2 = q.p2;
   assign gi.s1 = q.s1;
   assign gi.s2 = q.s2;
   assign gi.diff_en = (q.st == ST_DIFF);
   assign gi.prod_en = (q.st == ST_PROD);

   assign busy_out = (q.st != ST_IDLE);
   assign done_out = q.done;
   assign grade_out = q.grade;
   assign def_ptr_out = q.dptr;
   assign fuzzy_ptr_out = q.fptr;
   assign mem_req_out = (q.st == ST_FETCH) || (q.st == ST_STORE);
   assign mem_we_out = (q.st == ST_STORE);
   assign mem_addr_out = q.addr;
   assign mem_wdata_out = q.grade;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_vertical;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_STORE) && (q.s1 == SLOPE_VERTICAL) && (q.s2 == SLOPE_VERTICAL)
         && (q.ain >= q.p1) && (q.ain <= q.p2) |-> mem_wdata_out == GRADE_MAX;
   endproperty
   a_vertical: assert property (p_vertical) else $error("crisp inside not all ones");

   property p_step_one;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_SEL) && !gi.flag && (q.s2 == SLOPE_VERTICAL) |-> step1 == GRADE_MAX;
   endproperty
   a_step_one: assert property (p_step_one) else $error("step one not all ones");

   property p_step_two;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_SEL) && (q.s1 == SLOPE_VERTICAL) |=> q.grade == $past(step1);
   endproperty
   a_step_two: assert property (p_step_two) else $error("step two overwrote grade");

   property p_outside_zero;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_STORE) && ((q.ain < q.p1) || (q.ain > q.p2)) |-> mem_wdata_out == GRADE_ZERO;
   endproperty
   a_outside_zero: assert property (p_outside_zero) else $error("outside input nonzero");

   property p_reversed;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_SEL) && (q.p1 > q.p2) |=> grade_out == GRADE_ZERO;
   endproperty
   a_reversed: assert property (p_reversed) else $error("reversed points nonzero");

   property p_advance;
      @(posedge clock_in) disable iff (rst_in)
      (q.st == ST_STORE) && mem_ack_in |=> done_out
         && (def_ptr_out == $past(q.dptr) + ADDR_W'(DEF_STRIDE))
         && (fuzzy_ptr_out == $past(q.fptr) + ADDR_W'(FUZ_STRIDE));
   endproperty
   a_advance: assert property (p_advance) else $error("pointers not advanced");

   property p_store_addr;
      @(posedge clock_in) disable iff (rst_in)
      mem_req_out && mem_we_out |-> (mem_addr_out == q.fptr) && (mem_wdata_out == grade_out);
   endproperty
   a_store_addr: assert property (p_store_addr) else $error("store address wrong");

   c_normal: cover property (@(posedge clock_in) done_out && (grade_out == GRADE_MAX));
   c_slope: cover property (@(posedge clock_in) done_out && (grade_out != GRADE_MAX)
      && (grade_out != GRADE_ZERO));
   c_outside: cover property (@(posedge clock_in) (q.st == ST_SEL) && gi.flag);
   c_retry: cover property (@(posedge clock_in) busy_out && start_in);

endmodule : membership_grade_eval
`default_nettype wire

// ===== mem_model.sv
// Byte memory partner on the evaluator's request/acknowledge port
`timescale 1ns/1ps
`default_nettype none
module mem_model #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Request from the evaluator
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   // Wait cycles before each acknowledge
   input wire logic [3:0] wait_in,
   // Answer
   output logic ack_out,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:1023];
   logic [3:0] cnt_q;
   logic [7:0] last_q;

   assign ack_out = req_in && (cnt_q == wait_in);
   // Read data only valid in the acknowledge cycle, otherwise a changed value
   assign rdata_out = ack_out ? mem[addr_in[9:0]] : ~last_q;

   always @(posedge clock_in) begin
      if (rst_in) begin
         cnt_q <= 4'h0;
         last_q <= 8'h00;
      end else if (ack_out) begin
         cnt_q <= 4'h0;
         last_q <= rdata_out;
         if (we_in) begin
            mem[addr_in[9:0]] <= wdata_in;
         end
      end else if (req_in) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : mem_model
`default_nettype wire

// ===== membership_grade_eval_tb.sv
// Self-checking bench for the membership grade evaluator
`timescale 1ns/1ps
`default_nettype none
module membership_grade_eval_tb
   import mgrade_pkg::*;
;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic start_in = 1'b0;
   logic [7:0] value_in = 8'h00;
   logic [15:0] def_ptr_in = 16'h0000;
   logic [15:0] fuzzy_ptr_in = 16'h0000;
   logic busy_out, done_out, mem_req_out, mem_we_out, mem_ack_in;
   logic [7:0] grade_out, mem_wdata_out, mem_rdata_in;
   logic [15:0] def_ptr_out, fuzzy_ptr_out, mem_addr_out;
   logic [3:0] mem_wait = 4'h0;
   logic [15:0] fuz_next = 16'h0200;
   int error_cnt = 0;
   int checks = 0;

   always #5 clock_in = ~clock_in;

   membership_grade_eval #(.ADDR_W(16)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
      .start_in(start_in), .value_in(value_in), .def_ptr_in(def_ptr_in),
      .fuzzy_ptr_in(fuzzy_ptr_in), .busy_out(busy_out), .done_out(done_out),
      .grade_out(grade_out), .def_ptr_out(def_ptr_out), .fuzzy_ptr_out(fuzzy_ptr_out),
      .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));

   mem_model #(.ADDR_W(16)) u_mem (.clock_in(clock_in), .rst_in(rst_in),
      .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
      .wdata_in(mem_wdata_out), .wait_in(mem_wait), .ack_out(mem_ack_in),
      .rdata_out(mem_rdata_in));

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   function automatic logic [7:0] ref_grade(input logic [7:0] v, input logic [7:0] p1,
      input logic [7:0] p2, input logic [7:0] s1, input logic [7:0] s2);
      logic flag;
      logic [15:0] g1;
      logic [15:0] g2;
      logic [7:0] g;
      flag = (v < p1) || (v > p2);
      g1 = flag ? 16'h0000 : {8'h00, v - p1} * {8'h00, s1};
      g2 = flag ? 16'h0000 : {8'h00, p2 - v} * {8'h00, s2};
      g = ((s2 == 8'h00 || g2 > 16'h00FF) && !flag) ? 8'hFF : g2[7:0];
      if (!(s1 == 8'h00 || g1 > 16'h00FF)) begin
         g = g1[7:0];
      end
      return g;
   endfunction : ref_grade

   // One evaluation; poke retries start while busy with other operands
   task automatic run_eval(input logic [15:0] dp, input logic [15:0] fp, input logic [7:0] v,
      input bit poke);
      logic [7:0] exp;
      int n;
      exp = ref_grade(v, u_mem.mem[dp[9:0]], u_mem.mem[dp[9:0] + 10'h1],
         u_mem.mem[dp[9:0] + 10'h2], u_mem.mem[dp[9:0] + 10'h3]);
      u_mem.mem[fp[9:0]] = ~exp;
      @(posedge clock_in);
      start_in <= 1'b1;
      value_in <= v;
      def_ptr_in <= dp;
      fuzzy_ptr_in <= fp;
      n = 0;
      do begin
         @(posedge clock_in);
         start_in <= poke && n == 2;
         if (poke && n == 2) begin
            fuzzy_ptr_in <= fp + 16'h0008;
            value_in <= ~v;
         end
         #1;
         n++;
      end while (done_out !== 1'b1 && n < 100);
      check("done", 16'h0001, {15'h0000, done_out});
      check("grade", {8'h00, exp}, {8'h00, grade_out});
      check("stored", {8'h00, exp}, {8'h00, u_mem.mem[fp[9:0]]});
      check("def ptr", dp + 16'(DEF_STRIDE), def_ptr_out);
      check("fuzzy ptr", fp + 16'(FUZ_STRIDE), fuzzy_ptr_out);
   endtask : run_eval

   // Definition {p1,p2,s1,s2} and up to eight input values, high byte first
   task automatic run_set(input logic [15:0] dp, input logic [31:0] def,
      input logic [63:0] vals, input int nv);
      for (int i = 0; i < 4; i++) begin
         u_mem.mem[dp[9:0] + 10'(i)] = def[31-8*i -: 8];
      end
      for (int i = 0; i < nv; i++) begin
         run_eval(dp, fuz_next, vals[63-8*i -: 8], 1'b0);
         fuz_next = fuz_next + 16'h0001;
      end
   endtask : run_set

   task automatic t_normal();
      run_set(16'h0100, 32'h40C0_0808, 64'h003F_4041_6080_C0C1, 8);
      run_set(16'h0100, 32'h40C0_0808, 64'h50A0_BFFF_0000_0000, 4);
      $display("normal trapezoid test finished");
   endtask : t_normal

   task automatic t_crisp();
      run_set(16'h0104, 32'h50B0_0000, 64'h4F50_80B0_B100_0000, 5);
      run_set(16'h0108, 32'h50B0_0010, 64'h50A0_B0B1_0000_0000, 4);
      run_set(16'h010C, 32'h50B0_1000, 64'h4F50_58B0_0000_0000, 4);
      $display("vertical side test finished");
   endtask : t_crisp

   task automatic t_abnormal();
      run_set(16'h0110, 32'h60C0_0404, 64'h6070_90A0_C0C1_0000, 6);
      run_set(16'h0114, 32'h4080_0202, 64'h4060_8081_0000_0000, 4);
      run_set(16'h0118, 32'hC040_0808, 64'h0040_80C0_FF00_0000, 5);
      run_set(16'h011C, 32'h60C0_0004, 64'h6090_C0C1_0000_0000, 4);
      $display("abnormal definition test finished");
   endtask : t_abnormal

   // Slow memory, start retried while busy, labels chained via returned pointers
   task automatic t_slow();
      u_mem.mem[10'h308] = 8'hAF;
      @(posedge clock_in);
      mem_wait <= 4'h3;
      run_eval(16'h0100, 16'h0300, 8'h50, 1'b1);
      run_eval(def_ptr_out, fuzzy_ptr_out, 8'h70, 1'b0);
      run_eval(def_ptr_out, fuzzy_ptr_out, 8'h90, 1'b0);
      check("ignored store", 16'h00AF, {8'h00, u_mem.mem[10'h308]});
      $display("slow memory test finished");
   endtask : t_slow

   // Reset in mid evaluation: outputs clear, the pending store never lands, then a clean run
   task automatic t_reset();
      u_mem.mem[10'h310] = 8'h5A;
      @(posedge clock_in);
      start_in <= 1'b1;
      value_in <= 8'h80;
      def_ptr_in <= 16'h0100;
      fuzzy_ptr_in <= 16'h0310;
      @(posedge clock_in);
      start_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      check("busy", 16'h0001, {15'h0000, busy_out});
      check("read request", 16'h0002, {14'h0000, mem_req_out, mem_we_out});
      check("read addr", 16'h0100, mem_addr_out);
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      check("reset busy", 16'h0000, {14'h0000, busy_out, done_out});
      check("reset request", 16'h0000, {14'h0000, mem_req_out, mem_we_out});
      check("reset grade", 16'h0000, {8'h00, grade_out});
      check("reset def ptr", 16'h0000, def_ptr_out);
      @(posedge clock_in);
      rst_in <= 1'b0;
      run_eval(16'h0100, 16'h0311, 8'h80, 1'b0);
      check("aborted store", 16'h005A, {8'h00, u_mem.mem[10'h310]});
      $display("mid-run reset test finished");
   endtask : t_reset

   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      t_normal();
      t_crisp();
      t_abnormal();
      t_slow();
      t_reset();
      end_sim();
   end

   // About 50 evaluations of under 40 cycles each; allow several times that
   initial begin
      #100000;
      error_cnt++;
      $display("unexpected run length: expected end of tests, seen hang");
      end_sim();
   end
endmodule : membership_grade_eval_tb
`default_nettype wire
